// ---- mnce_dev.sv ----
// device end: executes mac and nonce commands
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "mnce_map.svh"
module mnce_dev
  import mnce_pkg::*;
#(
  parameter int SEL_BITS = `MNCE_SEL_BITS
) (
  input  wire logic                ref_clk_i,
  input  wire logic                rstn_i,
  mnce_if.dev                      link,
  output logic      [SEL_BITS-1:0] key_slot_o,
  input  wire logic [255:0]        key_data_i,
  input  wire logic [87:0]         otp_i,
  input  wire logic [71:0]         serial_i,
  input  wire logic                cfg_locked_i,
  output logic                     rng_req_o,
  output logic                     rng_seed_upd_o,
  input  wire logic                rng_done_i,
  input  wire logic [255:0]        rng_data_i,
  output logic                     sha_req_o,
  output logic      [703:0]        sha_msg_o,
  output logic      [6:0]          sha_len_o,
  input  wire logic                sha_done_i,
  input  wire logic [255:0]        sha_digest_i,
  input  wire logic                rw_temp_use_i,
  output logic                     rw_refuse_o,
  output logic                     temp_valid_o,
  output logic                     temp_origin_o,
  output logic      [255:0]        temp_digest_o
);

  // slot field is cut from a 16-bit selector
  if (SEL_BITS < 1 || SEL_BITS > 16) begin : g_chk
    $error("SEL_BITS must be 1 to 16");
  end

  mnce_dst_t     st_r;
  logic [7:0]    op_r;
  logic [7:0]    mode_r;
  logic [15:0]   param_r;
  logic [255:0]  data_r;
  logic [5:0]    len_r;
  logic [255:0]  rand_r;
  logic [255:0]  temp_digest_r;
  logic          temp_valid_r;
  logic          temp_origin_r;
  logic [703:0]  msg_r;
  logic [6:0]    msg_len_r;
  logic          resp_err_r;
  logic [5:0]    resp_len_r;
  logic [255:0]  resp_data_r;
  logic [SEL_BITS-1:0] key_slot_r;

  // command decode, all from latched fields
  wire is_mac    = (op_r == `MNCE_OP_MAC);
  wire is_nonce  = (op_r == `MNCE_OP_NONCE);
  wire uses_temp = mode_r[0] | mode_r[1];
  wire mac_rsv   = mode_r[7] | mode_r[3];
  // source check only when temp digest feeds the message
  wire mac_src_bad = uses_temp &
                     (!temp_valid_r | (mode_r[2] != temp_origin_r));
  // challenge must be present unless temp digest replaces it
  wire mac_len_bad = !mode_r[0] && (len_r != `MNCE_LEN_CHAL);
  wire mac_bad     = mac_rsv | mac_src_bad | mac_len_bad;
  wire non_pass    = (mode_r[1:0] == 2'h3);
  wire non_len_bad = non_pass ? (len_r != `MNCE_LEN_CHAL)
                              : (len_r != `MNCE_LEN_HOST_INPUT_VALUE);
  wire non_bad     = (mode_r[7:2] != 6'h00) || (mode_r[1:0] == 2'h2) ||
                     non_len_bad;
  wire cmd_bad     = is_mac ? mac_bad : (is_nonce ? non_bad : 1'b1);

  // mac message fields, gated by the mode bits
  wire [255:0] mac_first  = mode_r[1] ? temp_digest_r : key_data_i;
  wire [255:0] mac_second = mode_r[0] ? temp_digest_r : data_r;
  wire [63:0]  otp_lo     = (mode_r[4] | mode_r[5]) ? otp_i[87:24] : 64'h0;
  wire [23:0]  otp_hi     = mode_r[4] ? otp_i[23:0] : 24'h0;
  wire [31:0]  ser_mid    = mode_r[6] ? serial_i[39:8] : 32'h0;
  wire [15:0]  ser_low    = mode_r[6] ? serial_i[55:40] : 16'h0;
  // byte 0 of every field sits in the top lane; selector goes low byte first
  wire [703:0] mac_msg = {mac_first, mac_second, op_r, mode_r, param_r[7:0],
                          param_r[15:8], otp_lo, otp_hi, serial_i[7:0], ser_mid,
                          serial_i[71:56], ser_low};
  // before config lock the generator output is a fixed pattern
  wire [255:0] rand_val = cfg_locked_i ? rng_data_i : `MNCE_TEST_RAND;
  wire [703:0] non_msg  = {rand_val, data_r[255:96], op_r, mode_r,
                           param_r[7:0], 264'h0};

  // handshakes are combinational from state
  assign link.cmd_ready  = (st_r == MNCE_IDLE);
  assign link.resp_valid = (st_r == MNCE_RESP);
  assign link.resp_err   = resp_err_r;
  assign link.resp_len   = resp_len_r;
  assign link.resp_data  = resp_data_r;
  assign rng_req_o       = (st_r == MNCE_RNG);
  assign rng_seed_upd_o  = (mode_r[1:0] == 2'h0);
  assign sha_req_o       = (st_r == MNCE_SHA);
  assign sha_msg_o       = msg_r;
  assign sha_len_o       = msg_len_r;
  assign key_slot_o      = key_slot_r;
  assign temp_valid_o    = temp_valid_r;
  assign temp_origin_o   = temp_origin_r;
  assign temp_digest_o   = temp_digest_r;
  // pass-through digest must never reach read or write
  assign rw_refuse_o     = rw_temp_use_i &
                           (!temp_valid_r | (temp_origin_r == `MNCE_ORIGIN_IN));

  // command capture; slot lookup starts in the same cycle as check
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op_r       <= 8'h00;
      mode_r     <= 8'h00;
      param_r    <= 16'h0000;
      data_r     <= 256'h0;
      len_r      <= `MNCE_LEN_RST;
      key_slot_r <= '0;
    end else if (link.cmd_valid && st_r == MNCE_IDLE) begin
      op_r       <= link.cmd_opcode;
      mode_r     <= link.cmd_mode;
      param_r    <= link.cmd_param;
      data_r     <= link.cmd_data;
      len_r      <= link.cmd_len;
      key_slot_r <= link.cmd_param[SEL_BITS-1:0];
    end
  end

  // sequencer: check, optional random draw, hash unless refused or pass-through, answer
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r          <= MNCE_IDLE;
      rand_r        <= 256'h0;
      temp_digest_r <= 256'h0;
      temp_valid_r  <= 1'b0;
      temp_origin_r <= `MNCE_ORIGIN_RAND;
      msg_r         <= 704'h0;
      msg_len_r     <= 7'h00;
      resp_err_r    <= 1'b0;
      resp_len_r    <= 6'h00;
      resp_data_r   <= 256'h0;
    end else begin
      case (st_r)
        MNCE_IDLE: begin
          if (link.cmd_valid) begin
            st_r <= MNCE_CHECK;
          end
        end
        MNCE_CHECK: begin
          if (cmd_bad) begin
            // temp digest left alone on any refusal
            resp_err_r  <= 1'b1;
            resp_len_r  <= `MNCE_LEN_STATUS;
            resp_data_r <= {`MNCE_ERR_CODE, 248'h0};
            st_r        <= MNCE_RESP;
          end else if (is_mac) begin
            msg_r     <= mac_msg;
            msg_len_r <= `MNCE_MSG_MAC;
            st_r      <= MNCE_SHA;
          end else if (non_pass) begin
            temp_digest_r <= data_r;
            temp_valid_r  <= 1'b1;
            temp_origin_r <= `MNCE_ORIGIN_IN;
            resp_err_r    <= 1'b0;
            resp_len_r    <= `MNCE_LEN_STATUS;
            resp_data_r   <= 256'h0;
            st_r          <= MNCE_RESP;
          end else begin
            st_r <= MNCE_RNG;
          end
        end
        MNCE_RNG: begin
          if (rng_done_i) begin
            rand_r    <= rand_val;
            msg_r     <= non_msg;
            msg_len_r <= `MNCE_MSG_NONCE;
            st_r      <= MNCE_SHA;
          end
        end
        MNCE_SHA: begin
          if (sha_done_i) begin
            resp_err_r <= 1'b0;
            resp_len_r <= `MNCE_LEN_DIGEST;
            if (is_mac) begin
              resp_data_r <= sha_digest_i;
            end else begin
              temp_digest_r <= sha_digest_i;
              temp_valid_r  <= 1'b1;
              temp_origin_r <= `MNCE_ORIGIN_RAND;
              resp_data_r   <= rand_r;
            end
            st_r <= MNCE_RESP;
          end
        end
        MNCE_RESP: begin
          if (link.resp_ready) begin
            st_r <= MNCE_IDLE;
          end
        end
        default: begin
          st_r <= MNCE_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- mnce_map.svh ----
// constants for the mac and nonce command engine and its host
// How it works
// - low four selector bits pick slot
// - challenge 0 or 32 bytes, ignored if mode0
// - mac returns 32-byte digest
// - mac message assembled in fixed order
// - mode6 gates serial bytes 2-7
// - mode5 gates first eight otp bytes
// - mode4 gates all eleven otp bytes
// - mode2 must match origin flag
// - mode1 picks slot or temp digest
// - mode0 picks challenge or temp digest
// - host sends nonce 0x16, param zero
// - nonce hash of random, input, fields
// - hashed nonce sets valid, random origin
// - nonce returns 32 bytes or zero byte
// - pass-through copies input, input origin
// - refuse pass-through digest for read/write
// - mode0 updates seed, mode1 does not
// - unlocked generator gives fixed test pattern
// - host computes and keeps nonce digest
`ifndef MNCE_MAP_SVH
`define MNCE_MAP_SVH
`define MNCE_OP_MAC      8'h08
`define MNCE_OP_NONCE    8'h16
`define MNCE_SEL_BITS    4
`define MNCE_LEN_CHAL    6'h20
`define MNCE_LEN_HOST_INPUT_VALUE   6'h14
`define MNCE_LEN_DIGEST  6'h20
`define MNCE_LEN_STATUS  6'h01
`define MNCE_MSG_MAC     7'h58
`define MNCE_MSG_NONCE   7'h37
`define MNCE_TEST_RAND   {4{64'hFFFF0000FFFF0000}}
`define MNCE_ERR_CODE    8'h0F
`define MNCE_ORIGIN_RAND 1'b0
`define MNCE_ORIGIN_IN   1'b1
`define MNCE_REG_CMD     8'h00
`define MNCE_REG_CTRL    8'h04
`define MNCE_REG_LEN     8'h08
`define MNCE_REG_STATUS  8'h0C
`define MNCE_REG_DATA    8'h20
`define MNCE_REG_RESP    8'h40
`define MNCE_REG_NONCE   8'h60
`define MNCE_CMD_RST     32'h00000000
`define MNCE_LEN_RST     6'h00
`endif

// ---- mnce_pkg.sv ----
// types shared by both ends
package mnce_pkg;
  typedef enum logic [2:0] {
    MNCE_IDLE  = 3'h0,
    MNCE_CHECK = 3'h1,
    MNCE_RNG   = 3'h3,
    MNCE_SHA   = 3'h2,
    MNCE_RESP  = 3'h6
  } mnce_dst_t;
  typedef enum logic [1:0] {
    MNCE_H_IDLE = 2'h0,
    MNCE_H_SEND = 2'h1,
    MNCE_H_WAIT = 2'h3,
    MNCE_H_HASH = 2'h2
  } mnce_hst_t;
endpackage

// ---- mnce_if.sv ----
// command and response channel between host and engine
`timescale 1ns/1ps
interface mnce_if;
  logic         cmd_valid;
  logic         cmd_ready;
  logic [7:0]   cmd_opcode;
  logic [7:0]   cmd_mode;
  logic [15:0]  cmd_param;
  logic [255:0] cmd_data;
  logic [5:0]   cmd_len;
  logic         resp_valid;
  logic         resp_ready;
  logic         resp_err;
  logic [5:0]   resp_len;
  logic [255:0] resp_data;
  modport dev (input cmd_valid, cmd_opcode, cmd_mode, cmd_param, cmd_data, cmd_len,
               resp_ready, output cmd_ready, resp_valid, resp_err, resp_len, resp_data);
  modport host (output cmd_valid, cmd_opcode, cmd_mode, cmd_param, cmd_data, cmd_len,
                resp_ready, input cmd_ready, resp_valid, resp_err, resp_len, resp_data);
endinterface

// ---- mnce_host.sv ----
// host end: avalon registers, command issue, own nonce digest
`timescale 1ns/1ps
`include "mnce_map.svh"
module mnce_host
  import mnce_pkg::*;
(
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  mnce_if.host              link,
  input  wire logic [7:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  output logic              hsha_req_o,
  output logic      [703:0] hsha_msg_o,
  output logic      [6:0]   hsha_len_o,
  input  wire logic         hsha_done_i,
  input  wire logic [255:0] hsha_digest_i
);

  mnce_hst_t    st_r;
  logic [31:0]  cmd_r;
  logic [5:0]   len_r;
  logic [255:0] data_r;
  logic [255:0] resp_r;
  logic [255:0] nonce_r;
  logic         done_r;
  logic         err_r;
  logic         nonce_ok_r;
  logic [5:0]   rlen_r;
  logic         rvalid_r;
  logic [31:0]  rdata_r;
  logic [31:0]  rd_mux;

  // word slicing, byte 0 of each vector in the top lane
  function automatic logic [31:0] word_of(input logic [255:0] v, input logic [2:0] i);
    word_of = v[(3'h7 - i) * 32 +: 32];
  endfunction

  wire [2:0] widx     = avs_address[4:2];
  wire       in_data  = (avs_address[7:5] == 3'(`MNCE_REG_DATA >> 5));
  wire       in_resp  = (avs_address[7:5] == 3'(`MNCE_REG_RESP >> 5));
  wire       in_nonce = (avs_address[7:5] == 3'(`MNCE_REG_NONCE >> 5));
  wire       busy     = (st_r != MNCE_H_IDLE);
  wire       start    = avs_write && (avs_address == `MNCE_REG_CTRL) &&
                        avs_writedata[0] && !busy;
  // only a good hashed nonce needs the host-side digest
  wire       own_hash = !link.resp_err && (cmd_r[7:0] == `MNCE_OP_NONCE) &&
                        !cmd_r[9];

  // reads take one wait cycle, writes none
  assign avs_waitrequest = avs_read && !rvalid_r;
  assign avs_readdata    = rdata_r;
  assign link.cmd_valid  = (st_r == MNCE_H_SEND);
  assign link.cmd_opcode = cmd_r[7:0];
  assign link.cmd_mode   = cmd_r[15:8];
  assign link.cmd_param  = cmd_r[31:16];
  assign link.cmd_data   = data_r;
  assign link.cmd_len    = len_r;
  assign link.resp_ready = (st_r == MNCE_H_WAIT);
  assign hsha_req_o      = (st_r == MNCE_H_HASH);
  assign hsha_len_o      = `MNCE_MSG_NONCE;
  // same layout the device hashes: random, input, fields
  assign hsha_msg_o      = {resp_r, data_r[255:96], cmd_r[7:0], cmd_r[15:8],
                            cmd_r[23:16], 264'h0};

  // read decode; unmapped reads return zero
  always_comb begin
    if (avs_address == `MNCE_REG_CMD) begin
      rd_mux = cmd_r;
    end else if (avs_address == `MNCE_REG_LEN) begin
      rd_mux = {26'h0, len_r};
    end else if (avs_address == `MNCE_REG_STATUS) begin
      rd_mux = {18'h0, rlen_r, 4'h0, nonce_ok_r, err_r, done_r, busy};
    end else if (in_data) begin
      rd_mux = word_of(data_r, widx);
    end else if (in_resp) begin
      rd_mux = word_of(resp_r, widx);
    end else if (in_nonce) begin
      rd_mux = word_of(nonce_r, widx);
    end else begin
      rd_mux = 32'h0;
    end
  end

  // bus read pipeline
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
    end else begin
      rvalid_r <= avs_read && !rvalid_r;
      rdata_r  <= rd_mux;
    end
  end

  // writes to command fields are ignored while a command runs
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_r  <= `MNCE_CMD_RST;
      len_r  <= `MNCE_LEN_RST;
      data_r <= 256'h0;
    end else if (avs_write && !busy) begin
      if (avs_address == `MNCE_REG_CMD) begin
        cmd_r <= avs_writedata;
      end else if (avs_address == `MNCE_REG_LEN) begin
        len_r <= avs_writedata[5:0];
      end else if (in_data) begin
        data_r[(3'h7 - widx) * 32 +: 32] <= avs_writedata;
      end
    end
  end

  // command sequencer
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r       <= MNCE_H_IDLE;
      resp_r     <= 256'h0;
      nonce_r    <= 256'h0;
      done_r     <= 1'b0;
      err_r      <= 1'b0;
      nonce_ok_r <= 1'b0;
      rlen_r     <= 6'h00;
    end else begin
      case (st_r)
        MNCE_H_IDLE: begin
          if (start) begin
            done_r <= 1'b0;
            st_r   <= MNCE_H_SEND;
          end
        end
        MNCE_H_SEND: begin
          if (link.cmd_ready) begin
            st_r <= MNCE_H_WAIT;
          end
        end
        MNCE_H_WAIT: begin
          if (link.resp_valid) begin
            resp_r <= link.resp_data;
            err_r  <= link.resp_err;
            rlen_r <= link.resp_len;
            if (own_hash && cmd_r[9:8] != 2'h2) begin
              nonce_ok_r <= 1'b0;
              st_r       <= MNCE_H_HASH;
            end else begin
              if (!link.resp_err && cmd_r[7:0] == `MNCE_OP_NONCE) begin
                nonce_r    <= data_r;
                nonce_ok_r <= 1'b1;
              end
              done_r <= 1'b1;
              st_r   <= MNCE_H_IDLE;
            end
          end
        end
        MNCE_H_HASH: begin
          if (hsha_done_i) begin
            nonce_r    <= hsha_digest_i;
            nonce_ok_r <= 1'b1;
            done_r     <= 1'b1;
            st_r       <= MNCE_H_IDLE;
          end
        end
        default: begin
          st_r <= MNCE_H_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- mnce_checker.sv ----
// assertions on the host-device command channel
`timescale 1ns/1ps
module mnce_checker (
  input wire logic         ref_clk_i,
  input wire logic         rstn_i,
  input wire logic         cmd_valid,
  input wire logic         cmd_ready,
  input wire logic [7:0]   cmd_opcode,
  input wire logic [7:0]   cmd_mode,
  input wire logic [15:0]  cmd_param,
  input wire logic [255:0] cmd_data,
  input wire logic [5:0]   cmd_len,
  input wire logic         resp_valid,
  input wire logic         resp_ready,
  input wire logic         resp_err,
  input wire logic [5:0]   resp_len,
  input wire logic [255:0] resp_data
);
  logic [7:0] last_op_r;
  logic [7:0] last_mode_r;
  // remember the taken command, its answer comes later
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_op_r   <= 8'h00;
      last_mode_r <= 8'h00;
    end else if (cmd_valid && cmd_ready) begin
      last_op_r   <= cmd_opcode;
      last_mode_r <= cmd_mode;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_pass;
    cmd_valid && cmd_ready && cmd_opcode == 8'h16 && cmd_mode == 8'h03 && cmd_len == 6'h20;
  endsequence
  // error and pass-through answers come early, fixed latency from the note
  a_pass_answer: assert property (
    s_pass |-> ##2 resp_valid && !resp_err && resp_len == 6'h01 && resp_data[255:248] == 8'h00)
    else $error("pass-through answer wrong");
  a_nonce_bad_mode: assert property (
    s_take ##0 (cmd_opcode == 8'h16 && (cmd_mode[1:0] == 2'h2 || cmd_mode[7:2] != 6'h00))
    |-> ##2 resp_valid && resp_err && resp_data[255:248] == 8'h0F)
    else $error("bad nonce mode not refused");
  a_mac_reserved: assert property (
    s_take ##0 (cmd_opcode == 8'h08 && (cmd_mode[7] || cmd_mode[3])) |-> ##2 resp_valid && resp_err)
    else $error("mac reserved mode bit not refused");
  a_mac_no_chal: assert property (
    s_take ##0 (cmd_opcode == 8'h08 && !cmd_mode[0] && cmd_len != 6'h20) |-> ##2 resp_err)
    else $error("mac without challenge not refused");
  a_mac_resp_len: assert property (
    resp_valid && !resp_err && last_op_r == 8'h08 |-> resp_len == 6'h20)
    else $error("mac digest length wrong");
  a_nonce_resp_len: assert property (
    resp_valid && !resp_err && last_op_r == 8'h16 && last_mode_r[1:0] != 2'h3 |-> resp_len == 6'h20)
    else $error("nonce random length wrong");
  a_answer_bound: assert property (
    s_take |-> ##[2:60] resp_valid)
    else $error("no answer to command");
  a_resp_hold: assert property (
    resp_valid && !resp_ready |=> resp_valid && $stable(resp_data) && $stable(resp_len))
    else $error("answer changed before accepted");
  a_one_at_time: assert property (
    resp_valid |-> !cmd_ready)
    else $error("command accepted while answering");
  a_resp_done: assert property (
    resp_valid && resp_ready |=> !resp_valid)
    else $error("answer stays after accept");
endmodule

// ---- tb.sv ----
// self-checking bench joining host and device ends
`timescale 1ns/1ps
module tb;
  logic         ref_clk_i, rstn_i, avs_read, avs_write, avs_waitrequest;
  logic [7:0]   avs_address;
  logic [31:0]  avs_writedata, avs_readdata, word;
  logic [3:0]   key_slot;
  logic [255:0] key_data, rng_data, temp_digest, num, rnd;
  logic [87:0]  otp;
  logic [71:0]  serial;
  logic         cfg_locked, rng_req, seed_upd, seed_cap, rng_done, sha_req, sha_done;
  logic         hsha_req, hsha_done, rw_use, rw_refuse, temp_valid, temp_origin;
  logic [703:0] sha_msg, hsha_msg, msg_cap, hmsg_cap, exp;
  logic [6:0]   sha_len, hsha_len;
  int           err_total, comparisons;
  localparam logic [255:0] DDIG = {8{32'hA5C3_0F1E}};
  localparam logic [255:0] HDIG = {8{32'h3C5A_9617}};
  mnce_if lnk ();
  mnce_dev mnce_dev_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(lnk), .key_slot_o(key_slot),
    .key_data_i(key_data), .otp_i(otp), .serial_i(serial), .cfg_locked_i(cfg_locked),
    .rng_req_o(rng_req), .rng_seed_upd_o(seed_upd), .rng_done_i(rng_done),
    .rng_data_i(rng_data), .sha_req_o(sha_req), .sha_msg_o(sha_msg), .sha_len_o(sha_len),
    .sha_done_i(sha_done), .sha_digest_i(DDIG), .rw_temp_use_i(rw_use),
    .rw_refuse_o(rw_refuse), .temp_valid_o(temp_valid), .temp_origin_o(temp_origin),
    .temp_digest_o(temp_digest));
  mnce_host mnce_host_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(lnk),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hsha_req_o(hsha_req), .hsha_msg_o(hsha_msg),
    .hsha_len_o(hsha_len), .hsha_done_i(hsha_done), .hsha_digest_i(HDIG));
  mnce_checker mnce_checker_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .cmd_valid(lnk.cmd_valid), .cmd_ready(lnk.cmd_ready), .cmd_opcode(lnk.cmd_opcode),
    .cmd_mode(lnk.cmd_mode), .cmd_param(lnk.cmd_param), .cmd_data(lnk.cmd_data),
    .cmd_len(lnk.cmd_len), .resp_valid(lnk.resp_valid), .resp_ready(lnk.resp_ready),
    .resp_err(lnk.resp_err), .resp_len(lnk.resp_len), .resp_data(lnk.resp_data));
  // far-side engines answer one cycle after a request; capture what they saw
  always @(posedge ref_clk_i) begin
    rng_done  <= rng_req & ~rng_done;
    sha_done  <= sha_req & ~sha_done;
    hsha_done <= hsha_req & ~hsha_done;
    if (sha_req) msg_cap <= sha_msg;
    if (hsha_req) hmsg_cap <= hsha_msg;
    if (rng_req) seed_cap <= seed_upd;
  end
  task automatic chk(input logic [703:0] got, input logic [703:0] want, input string what);
    comparisons++;
    if (got !== want) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  // one avalon transfer; waitrequest and readdata read at the edge, before it updates them
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    avs_address   <= a;
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_writedata <= d;
    @(posedge ref_clk_i);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk_i);
    word = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  // load data, length and fields, start, poll until done; leaves status in word
  task automatic cmd(input logic [7:0] op, input logic [7:0] md, input logic [15:0] pr,
                     input logic [5:0] ln, input logic [255:0] dat);
    for (int i = 0; i < 8; i++) bus(8'h20 + 8'(4 * i), 1'b1, dat[255 - 32 * i -: 32]);
    bus(8'h08, 1'b1, {26'h0, ln});
    bus(8'h00, 1'b1, {pr, md, op});
    bus(8'h04, 1'b1, 32'h1);
    do bus(8'h0C, 1'b0, 32'h0); while (word[1] !== 1'b1);
  endtask
  task automatic t_pass();
    num = {8{32'h1357_9BDF}};
    rw_use <= 1'b1;
    cmd(8'h16, 8'h03, 16'h0, 6'h20, num);
    chk({word[2], word[13:8]}, 7'h01, "pass status");
    chk({temp_valid, temp_origin, temp_digest}, {2'b11, num}, "pass copy");
    chk(rw_refuse, 1'b1, "pass refuse");
    bus(8'h40, 1'b0, 32'h0);
    chk(word[31:24], 8'h00, "pass byte");
  endtask
  task automatic t_nonce();
    for (int m = 0; m < 2; m++) begin
      cfg_locked <= m[0];
      cmd(8'h16, 8'(m), 16'h0, 6'h14, num);
      rnd = m[0] ? rng_data : {4{64'hFFFF0000FFFF0000}};
      exp = {rnd, num[255:96], 8'h16, 8'(m), 8'h00, 264'h0};
      chk(msg_cap, exp, "nonce msg");
      chk(hmsg_cap, exp, "host msg");
      chk({sha_len, hsha_len}, {7'h37, 7'h37}, "nonce length");
      chk(seed_cap, !m[0], "seed update");
      chk({temp_valid, temp_origin, temp_digest}, {2'b10, DDIG}, "nonce temp");
      chk({rw_refuse, word[2], word[13:8]}, 8'h20, "nonce status");
      bus(8'h40, 1'b0, 32'h0);
      chk(word, rnd[255:224], "nonce random");
      bus(8'h7C, 1'b0, 32'h0);
      chk(word, HDIG[31:0], "host digest");
    end
  endtask
  task automatic t_mac();
    logic [7:0] md [4] = '{8'h00, 8'h20, 8'h10, 8'h60};
    for (int i = 0; i < 4; i++) begin
      cmd(8'h08, md[i], 16'h1235, 6'h20, num);
      exp = {key_data, num, 8'h08, md[i], 16'h3512,
             (md[i][5] | md[i][4]) ? otp[87:24] : 64'h0, md[i][4] ? otp[23:0] : 24'h0,
             serial[7:0], md[i][6] ? serial[39:8] : 32'h0, serial[71:56],
             md[i][6] ? serial[55:40] : 16'h0};
      chk(msg_cap, exp, "mac msg");
      chk(key_slot, 4'h5, "slot");
      chk(sha_len, 7'h58, "mac length");
      bus(8'h40, 1'b0, 32'h0);
      chk(word, DDIG[255:224], "mac digest");
    end
  endtask
  task automatic t_temp();
    cmd(8'h08, 8'h03, 16'h0002, 6'h00, 256'h0);
    exp = {DDIG, DDIG, 8'h08, 8'h03, 16'h0200, 88'h0, serial[7:0], 32'h0, serial[71:56], 16'h0};
    chk({word[2], msg_cap}, {1'b0, exp}, "mac temp");
    cmd(8'h08, 8'h07, 16'h0002, 6'h00, 256'h0);
    chk(word[2], 1'b1, "origin mismatch");
    cmd(8'h16, 8'h02, 16'h0, 6'h14, num);
    chk(word[2], 1'b1, "mode two");
    cmd(8'h16, 8'h04, 16'h0, 6'h14, num);
    chk({word[2], temp_digest}, {1'b1, DDIG}, "reserved bit");
    bus(8'hF0, 1'b0, 32'h0);
    chk(word, 32'h0, "unmapped read");
  endtask
  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // clock at 100 MHz
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // watchdog: the whole run needs a few hundred cycles
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  initial begin
    {rstn_i, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {rw_use, cfg_locked} = '0;
    key_data = {8{32'h8E41_D2B7}};
    rng_data = {8{32'h6B1F_C054}};
    otp      = 88'hA1B2C3D4E5F60718293A4B;
    serial   = 72'h0123456789ABCDEF5A;
    repeat (20) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    t_pass();
    t_nonce();
    t_mac();
    t_temp();
    print_verdict();
  end
endmodule
